// file: sgc_pkg.sv
package sgc_pkg;

	// clock and bus geometry
	localparam longint unsigned CLK_HZ     = 40_000_000;
	localparam int              ADDR_W     = 8;
	localparam int              DATA_W     = 32;
	localparam int              REG_W      = 16;
	localparam int              BANK_W     = 6;

	// register indices inside a bank; byte address is four times the index
	localparam logic [3:0] IDX_MCAST_0  = 4'h0;
	localparam logic [3:0] IDX_MCAST_1  = 4'h2;
	localparam logic [3:0] IDX_MCAST_2  = 4'h4;
	localparam logic [3:0] IDX_MCAST_3  = 4'h6;
	localparam logic [3:0] IDX_RX_CTRL  = 4'h8;
	localparam logic [3:0] IDX_IDENT    = 4'h0;
	localparam logic [3:0] IDX_CTRL_ONE = 4'h2;
	localparam logic [3:0] IDX_STATUS   = 4'h8;
	localparam logic [3:0] IDX_BANK_SEL = 4'hE;

	// bank numbers
	localparam logic [BANK_W-1:0] BANK_MCAST   = 6'h13;
	localparam logic [BANK_W-1:0] BANK_RSV_LO  = 6'h14;
	localparam logic [BANK_W-1:0] BANK_RSV_HI  = 6'h1F;
	localparam logic [BANK_W-1:0] BANK_SWITCH  = 6'h20;
	localparam logic [BANK_W-1:0] BANK_RESET   = 6'h00;

	// switch_global_control_one fields
	localparam int CTL_PASS_ALL   = 15;
	localparam int CTL_TX_FC      = 13;
	localparam int CTL_RX_FC      = 12;
	localparam int CTL_LEN_CHECK  = 11;
	localparam int CTL_AGE_EN     = 10;
	localparam int CTL_FAST_AGE   = 9;
	localparam int CTL_AGGR_BO    = 8;
	localparam int CTL_INGR_FC    = 5;
	localparam int CTL_RX_2K      = 4;
	localparam int CTL_PASS_PAUSE = 3;
	localparam int CTL_LINK_AGE   = 0;
	localparam logic [REG_W-1:0] CTL_ONE_RESET = 16'h3410;

	// switch_ident_and_start fields
	localparam int ID_START       = 0;
	localparam int ID_REV_LSB     = 1;
	localparam int ID_CHIP_LSB    = 4;
	localparam int ID_FAMILY_LSB  = 8;

	// receive_control_word fields
	localparam int RXC_ALL        = 0;
	localparam int RXC_MCAST      = 1;

	// status word fields
	localparam int ST_FAST_ONCE   = 0;
	localparam int ST_LINK_LSB    = 1;
	localparam int ST_RUNNING     = 3;

	localparam logic [REG_W-1:0] MCAST_RESET = 16'h0000;
	localparam logic [REG_W-1:0] ZERO_WORD   = 16'h0000;

	// frame limits
	localparam logic [15:0] LEN_TYPE_LIMIT = 16'h05DC;
	localparam logic [10:0] MAX_LEN_NO_2K  = 11'h7D0;

	// aging periods
	localparam longint unsigned FAST_AGE_US   = 800;
	localparam longint unsigned NORMAL_AGE_S  = 300;
	localparam longint unsigned FAST_AGE_CYC  = FAST_AGE_US * CLK_HZ / 1_000_000;
	localparam longint unsigned NORMAL_AGE_CYC = NORMAL_AGE_S * CLK_HZ;
	localparam int              AGE_CNT_W     = 34;

	typedef struct packed {
		logic        valid;
		logic [47:0] dest_addr;
		logic [15:0] length_type;
		logic [10:0] payload_len;
		logic [10:0] frame_len;
		logic        crc_bad;
		logic        runt;
		logic        is_pause;
		logic        ingress_over;
	} sgc_frame_s;

	typedef enum logic [2:0] {
		RSN_NONE      = 3'b000,
		RSN_STOPPED   = 3'b001,
		RSN_MCAST     = 3'b010,
		RSN_BAD       = 3'b011,
		RSN_LENGTH    = 3'b100,
		RSN_SIZE      = 3'b101,
		RSN_PAUSE     = 3'b110,
		RSN_INGRESS   = 3'b111
	} sgc_reason_e;

	typedef struct packed {
		logic        valid;
		logic        forward;
		logic        send_pause;
		logic        honor_pause;
		sgc_reason_e reason;
	} sgc_verdict_s;

	typedef struct packed {
		logic switch_run;
		logic tx_flow_ctl;
		logic rx_flow_ctl;
		logic aging_on;
		logic fast_aging;
		logic aggressive_backoff;
	} sgc_ctrl_s;

endpackage : sgc_pkg

// file: sgc_mc_hash.sv
`timescale 1ns/1ps
module sgc_mc_hash
	import sgc_pkg::*;
(
	input  wire logic [47:0] dest_addr,
	output logic      [5:0]  hash
);

	// ethernet crc, first octet first, each octet lsb first
	function automatic logic [31:0] crc_da(input logic [47:0] da);
		logic [31:0] c;
		logic        fb;
		c = 32'hFFFFFFFF;
		for (int o = 0; o < 6; o++) begin
			for (int b = 0; b < 8; b++) begin
				fb = c[31] ^ da[47 - 8 * o - 7 + b];
				c  = {c[30:0], 1'b0};
				if (fb) begin
					c = c ^ 32'h04C11DB7;
				end
			end
		end
		return c;
	endfunction : crc_da

	logic [31:0] crc;

	assign crc  = crc_da(dest_addr);
	assign hash = crc[31:26];

endmodule : sgc_mc_hash

// file: sgc_age_timer.sv
`timescale 1ns/1ps
module sgc_age_timer
	import sgc_pkg::*;
#(
	parameter longint unsigned NORMAL_CYC = NORMAL_AGE_CYC,
	parameter longint unsigned FAST_CYC   = FAST_AGE_CYC
)(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic enable,
	input  wire logic fast,
	input  wire logic restart,
	output logic      tick
);

	localparam logic [AGE_CNT_W-1:0] NORMAL_LAST = AGE_CNT_W'(NORMAL_CYC - 1);
	localparam logic [AGE_CNT_W-1:0] FAST_LAST   = AGE_CNT_W'(FAST_CYC - 1);

	logic [AGE_CNT_W-1:0] cnt_q;
	logic [AGE_CNT_W-1:0] cnt_d;
	logic                 tick_q;
	logic                 at_end;

	// switching period takes effect at once, so a long count never delays fast aging
	assign at_end = fast ? (cnt_q >= FAST_LAST) : (cnt_q >= NORMAL_LAST);
	assign cnt_d  = (restart || !enable || at_end) ? '0 : cnt_q + 1'b1;
	assign tick   = tick_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= enable && !restart && at_end;
		end
	end

endmodule : sgc_age_timer

// file: sgc_global_regs.sv
// Summary of operation
// - multicast frame passes when its hash table bit is set; table resets to zero
// - receive-all or receive-multicast control accepts every multicast frame
// - six-bit crc hash; top two bits pick the word, rest the bit
// - banks twenty to thirty-one reserved, bank select still reachable there
// - ident word shows read-only family, chip and revision codes
// - pass-all forwards bad frames, only while sniffer mode is on
// - bit thirteen enables pause generation, reset one; clear means none
// - bit twelve enables honouring received pause, reset one
// - bit eleven drops frames whose length field mismatches, below threshold
// - bit ten enables aging, reset one
// - bit nine selects fast aging period
// - bit eight selects aggressive half-duplex back-off
// - ingress overrun passes the frame when enabled, sending pause if bit thirteen set; otherwise drops it
// - bit four allows 2K frames, reset one; clear drops frames over limit
// - pass-pause bit forwards pause frames instead of filtering
// - link-age bit makes link loss run one fast age cycle, then normal
// - any port unplug ages out all learned addresses
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module sgc_global_regs
	import sgc_pkg::*;
#(
	parameter logic [7:0]      FAMILY_CODE = 8'h5A,
	parameter logic [3:0]      CHIP_CODE   = 4'h3,
	parameter logic [2:0]      REV_CODE    = 3'h2,
	parameter longint unsigned NORMAL_CYC  = NORMAL_AGE_CYC,
	parameter longint unsigned FAST_CYC    = FAST_AGE_CYC
)(
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire sgc_frame_s        frame_in,
	input  wire logic              sniff_mode,
	input  wire logic [1:0]        port_link,
	output sgc_verdict_s           verdict,
	output sgc_ctrl_s              ctrl,
	output logic                   age_tick,
	output logic                   age_flush
);

	// register storage
	logic [REG_W-1:0]  mcast_q [4];
	logic [REG_W-1:0]  rx_ctrl_q;
	logic [REG_W-1:0]  ctrl_one_q;
	logic              start_q;
	logic [BANK_W-1:0] bank_q;

	// bus answer
	logic [DATA_W-1:0] prdata_q;
	logic              pready_q;
	logic              pslverr_q;

	// link pins, two-stage synchroniser
	logic [1:0]        link_meta_q;
	logic [1:0]        link_sync_q;
	logic [1:0]        link_prev_q;

	// aging state
	logic              fast_once_q;
	logic              fast_aging_q;
	logic              age_tick_q;
	logic              age_flush_q;
	logic              timer_tick;

	// frame path
	sgc_verdict_s      verdict_q;
	logic [5:0]        hash;

	// address decode
	wire  [3:0]        idx        = paddr[5:2];
	wire               addr_ok    = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:6] == '0);
	wire               in_mcast   = bank_q == BANK_MCAST;
	wire               in_switch  = bank_q == BANK_SWITCH;
	wire               hit_bank   = addr_ok && (idx == IDX_BANK_SEL);
	wire               hit_mc0    = addr_ok && in_mcast && (idx == IDX_MCAST_0);
	wire               hit_mc1    = addr_ok && in_mcast && (idx == IDX_MCAST_1);
	wire               hit_mc2    = addr_ok && in_mcast && (idx == IDX_MCAST_2);
	wire               hit_mc3    = addr_ok && in_mcast && (idx == IDX_MCAST_3);
	wire               hit_rxc    = addr_ok && in_mcast && (idx == IDX_RX_CTRL);
	wire               hit_ident  = addr_ok && in_switch && (idx == IDX_IDENT);
	wire               hit_ctl    = addr_ok && in_switch && (idx == IDX_CTRL_ONE);
	wire               hit_status = addr_ok && in_switch && (idx == IDX_STATUS);
	// reserved banks fall through here: nothing but bank select answers
	wire               hit_any    = hit_bank || hit_mc0 || hit_mc1 || hit_mc2 || hit_mc3
	                                || hit_rxc || hit_ident || hit_ctl || hit_status;

	// access phase takes two cycles: the first loads read data, the second completes
	wire               acc_first  = psel && penable && !pready_q;
	wire               acc_done   = psel && penable && pready_q;
	wire               wr_en      = acc_done && pwrite && hit_any;
	wire [REG_W-1:0]   wdata      = pwdata[REG_W-1:0];

	wire [REG_W-1:0]   ident_word = {FAMILY_CODE, CHIP_CODE, REV_CODE, start_q};
	wire [REG_W-1:0]   status_word;

	assign status_word = {12'h000, start_q, link_sync_q, fast_once_q};

	wire [REG_W-1:0]   rd_word =
		hit_bank   ? {{(REG_W-BANK_W){1'b0}}, bank_q} :
		hit_mc0    ? mcast_q[0] :
		hit_mc1    ? mcast_q[1] :
		hit_mc2    ? mcast_q[2] :
		hit_mc3    ? mcast_q[3] :
		hit_rxc    ? rx_ctrl_q :
		hit_ident  ? ident_word :
		hit_ctl    ? ctrl_one_q :
		hit_status ? status_word :
		ZERO_WORD;

	// APB answer
	always_ff @(posedge clk) begin
		if (rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= acc_first;
			pslverr_q <= acc_first && !hit_any;
			if (acc_first) begin
				prdata_q <= {{(DATA_W-REG_W){1'b0}}, rd_word};
			end
		end
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;

	// register writes; multicast, receive and control-one words stored whole so reserved bits read back
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 4; i++) begin
				mcast_q[i] <= MCAST_RESET;
			end
			rx_ctrl_q  <= ZERO_WORD;
			ctrl_one_q <= CTL_ONE_RESET;
			start_q    <= 1'b0;
			bank_q     <= BANK_RESET;
		end else if (wr_en) begin
			if (hit_bank) begin
				bank_q <= wdata[BANK_W-1:0];
			end
			if (hit_mc0) begin
				mcast_q[0] <= wdata;
			end
			if (hit_mc1) begin
				mcast_q[1] <= wdata;
			end
			if (hit_mc2) begin
				mcast_q[2] <= wdata;
			end
			if (hit_mc3) begin
				mcast_q[3] <= wdata;
			end
			if (hit_rxc) begin
				rx_ctrl_q <= wdata;
			end
			if (hit_ident) begin
				start_q <= wdata[ID_START];
			end
			if (hit_ctl) begin
				ctrl_one_q <= wdata;
			end
		end
	end

	// named control bits
	wire c_pass_all   = ctrl_one_q[CTL_PASS_ALL];
	wire c_tx_fc      = ctrl_one_q[CTL_TX_FC];
	wire c_rx_fc      = ctrl_one_q[CTL_RX_FC];
	wire c_len_check  = ctrl_one_q[CTL_LEN_CHECK];
	wire c_age_en     = ctrl_one_q[CTL_AGE_EN];
	wire c_fast_age   = ctrl_one_q[CTL_FAST_AGE];
	wire c_aggr_bo    = ctrl_one_q[CTL_AGGR_BO];
	wire c_ingr_fc    = ctrl_one_q[CTL_INGR_FC];
	wire c_rx_2k      = ctrl_one_q[CTL_RX_2K];
	wire c_pass_pause = ctrl_one_q[CTL_PASS_PAUSE];
	wire c_link_age   = ctrl_one_q[CTL_LINK_AGE];
	wire c_rx_all     = rx_ctrl_q[RXC_ALL];
	wire c_rx_mcast   = rx_ctrl_q[RXC_MCAST];

	assign ctrl.switch_run         = start_q;
	assign ctrl.tx_flow_ctl        = c_tx_fc;
	assign ctrl.rx_flow_ctl        = c_rx_fc;
	assign ctrl.aging_on           = c_age_en;
	assign ctrl.fast_aging         = fast_aging_q;
	assign ctrl.aggressive_backoff = c_aggr_bo;

	// multicast hash lookup
	sgc_mc_hash u_hash (
		.dest_addr (frame_in.dest_addr),
		.hash      (hash)
	);

	wire [REG_W-1:0] hash_word = mcast_q[hash[5:4]];
	wire             hash_bit  = hash_word[hash[3:0]];
	wire             is_group  = frame_in.dest_addr[40];
	wire             mc_ok     = !is_group || c_rx_all || c_rx_mcast || hash_bit;

	// pass-all is a debug aid; without sniffing it must not leak bad frames
	wire             is_bad    = frame_in.crc_bad || frame_in.runt;
	wire             bad_ok    = !is_bad || (c_pass_all && sniff_mode);

	wire             len_field = frame_in.length_type < LEN_TYPE_LIMIT;
	wire             len_match = frame_in.length_type == {5'h00, frame_in.payload_len};
	wire             len_ok    = !c_len_check || !len_field || len_match;

	wire             size_ok   = c_rx_2k || (frame_in.frame_len <= MAX_LEN_NO_2K);
	wire             pause_ok  = !frame_in.is_pause || c_pass_pause;
	wire             ingr_ok   = !frame_in.ingress_over || c_ingr_fc;

	wire             fwd       = start_q && mc_ok && bad_ok && len_ok && size_ok
	                             && pause_ok && ingr_ok;
	// pause on ingress overrun still needs transmit flow control on
	wire             send_p    = start_q && frame_in.ingress_over && c_ingr_fc && c_tx_fc;
	wire             honor_p   = start_q && frame_in.is_pause && c_rx_fc;

	sgc_reason_e     reason;

	assign reason = !start_q  ? RSN_STOPPED :
	                !bad_ok   ? RSN_BAD :
	                !size_ok  ? RSN_SIZE :
	                !len_ok   ? RSN_LENGTH :
	                !mc_ok    ? RSN_MCAST :
	                !pause_ok ? RSN_PAUSE :
	                !ingr_ok  ? RSN_INGRESS :
	                RSN_NONE;

	always_ff @(posedge clk) begin
		if (rst) begin
			verdict_q <= '0;
		end else begin
			verdict_q.valid       <= frame_in.valid;
			verdict_q.forward     <= frame_in.valid && fwd;
			verdict_q.send_pause  <= frame_in.valid && send_p;
			verdict_q.honor_pause <= frame_in.valid && honor_p;
			verdict_q.reason      <= frame_in.valid ? reason : RSN_NONE;
		end
	end

	assign verdict = verdict_q;

	// link pins come from the phy side, outside this clock
	always_ff @(posedge clk) begin
		if (rst) begin
			link_meta_q <= 2'b00;
			link_sync_q <= 2'b00;
			link_prev_q <= 2'b00;
		end else begin
			link_meta_q <= port_link;
			link_sync_q <= link_meta_q;
			link_prev_q <= link_sync_q;
		end
	end

	wire link_lost = |(link_prev_q & ~link_sync_q);

	// restart the period on link loss so the single fast cycle runs in full
	sgc_age_timer #(
		.NORMAL_CYC (NORMAL_CYC),
		.FAST_CYC   (FAST_CYC)
	) u_timer (
		.clk     (clk),
		.rst     (rst),
		.enable  (c_age_en),
		.fast    (c_fast_age || fast_once_q),
		.restart (link_lost && c_link_age),
		.tick    (timer_tick)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			fast_once_q  <= 1'b0;
			fast_aging_q <= 1'b0;
			age_tick_q   <= 1'b0;
			age_flush_q  <= 1'b0;
		end else begin
			// registered so the output level comes from a flop, one cycle behind
			fast_aging_q <= c_fast_age || fast_once_q;
			age_tick_q  <= timer_tick;
			age_flush_q <= link_lost;
			// a new link loss wins over the end of the current fast cycle
			if (link_lost && c_link_age) begin
				fast_once_q <= 1'b1;
			end else if (timer_tick || !c_link_age) begin
				fast_once_q <= 1'b0;
			end
		end
	end

	assign age_tick  = age_tick_q;
	assign age_flush = age_flush_q;

endmodule : sgc_global_regs

// file: sgc_chk_sva.sv
`timescale 1ns/1ps
module sgc_chk
	import sgc_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire sgc_frame_s        frame_in,
	input wire logic              sniff_mode,
	input wire logic [1:0]        port_link,
	input wire sgc_verdict_s      verdict,
	input wire sgc_ctrl_s         ctrl,
	input wire logic              age_tick,
	input wire logic              age_flush
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("access not answered after one wait");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held two cycles");
	err_zero_a: assert property (pslverr |-> pready && prdata == '0)
		else $error("error answer with data");
	stop_drop_a: assert property (frame_in.valid && !ctrl.switch_run |=>
		!verdict.forward && verdict.reason == RSN_STOPPED) else $error("stopped switch forwarded");
	bad_drop_a: assert property (frame_in.valid && frame_in.crc_bad && !sniff_mode |=>
		!verdict.forward) else $error("bad frame passed without sniffer");
	tx_pause_a: assert property (verdict.send_pause |->
		$past(ctrl.tx_flow_ctl) && $past(frame_in.ingress_over)) else $error("pause sent wrongly");
	rx_pause_a: assert property (verdict.honor_pause |->
		$past(ctrl.rx_flow_ctl) && $past(frame_in.is_pause)) else $error("pause honoured wrongly");
	// tick trails the enable by two stages
	no_age_a: assert property (!ctrl.aging_on && !$past(ctrl.aging_on)
		&& !$past(ctrl.aging_on, 2) |-> !age_tick) else $error("age tick while aging off");
	flush_a: assert property ($fell(port_link[0]) || $fell(port_link[1]) |-> ##[2:6] age_flush)
		else $error("no flush after link loss");
	flush_pulse_a: assert property (age_flush |=> !age_flush)
		else $error("flush longer than a cycle");
endmodule : sgc_chk

bind sgc_global_regs sgc_chk sgc_chk_inst (
	.clk       (clk),
	.rst       (rst),
	.psel      (psel),
	.penable   (penable),
	.pwrite    (pwrite),
	.paddr     (paddr),
	.pwdata    (pwdata),
	.prdata    (prdata),
	.pready    (pready),
	.pslverr   (pslverr),
	.frame_in  (frame_in),
	.sniff_mode(sniff_mode),
	.port_link (port_link),
	.verdict   (verdict),
	.ctrl      (ctrl),
	.age_tick  (age_tick),
	.age_flush (age_flush)
);

// file: sgc_host.sv
`timescale 1ns/1ps
module sgc_host
	import sgc_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              pready,
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic      [ADDR_W-1:0] paddr,
	output logic      [DATA_W-1:0] pwdata
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// software starts the switch only through this path
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// released bus shows junk, never the old request
		pwrite <= ~w;
		paddr <= ~a;
		pwdata <= ~d;
	endtask : xfer
endmodule : sgc_host

// file: switch_global_config_regs_test.sv
`timescale 1ns/1ps
module switch_global_config_regs_test
	import sgc_pkg::*;
;
	localparam logic [7:0] FAM = 8'h5A; // arbitrary code
	localparam logic [3:0] CHP = 4'h3; // arbitrary code
	localparam logic [2:0] REV = 3'h2; // arbitrary code
	localparam logic [ADDR_W-1:0] ABK = 8'h38;
	logic              clk = 1'b0;
	logic              rst = 1'b1;
	logic              psel, penable, pwrite, pready, pslverr, sniff_mode, age_tick, age_flush;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata;
	logic [1:0]        port_link;
	sgc_frame_s        frame_in;
	sgc_verdict_s      verdict;
	sgc_ctrl_s         ctrl;
	logic [32:0]       rq[$];
	logic [5:0]        vq[$];
	logic [31:0]       seed;
	logic [5:0]        b;
	logic [15:0]       msk;
	int                miscompares, checked, n;

	always #12.5 clk = ~clk;

	sgc_global_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHP), .REV_CODE(REV),
		.NORMAL_CYC(200), .FAST_CYC(20)) sgc_global_regs_inst (
		.clk(clk),
		.rst(rst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.frame_in(frame_in),
		.sniff_mode(sniff_mode),
		.port_link(port_link),
		.verdict(verdict),
		.ctrl(ctrl),
		.age_tick(age_tick),
		.age_flush(age_flush)
	);

	sgc_host sgc_host_inst (
		.clk(clk),
		.pready(pready),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// reference hash: crc, first octet first, bits lsb first, top six bits
	function automatic logic [5:0] hsh(input logic [47:0] a);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		for (int i = 0; i < 48; i++)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ a[40 - 8 * (i / 8) + i % 8]) ? 32'h04C11DB7 : 32'h0);
		return c[31:26];
	endfunction : hsh

	function automatic logic [ADDR_W-1:0] ad(input logic [3:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad

	task automatic chk(input logic [32:0] s, input logic [32:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		sgc_host_inst.xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [32:0] e);
		rq.push_back(e);
		sgc_host_inst.xfer(1'b0, a, 32'h0);
	endtask : rd

	// e: forward, send pause, honour pause, reason
	task automatic send(input logic [5:0] e);
		vq.push_back(e);
		@(posedge clk);
		frame_in.valid <= 1'b1;
		@(posedge clk);
		frame_in.valid <= 1'b0;
	endtask : send

	// k: crc bad, pause, ingress over, sniffer
	task automatic fc(input logic [15:0] c, input logic [3:0] k, input logic [10:0] len,
		input logic [15:0] lt, input logic [5:0] e);
		wr(ad(IDX_CTRL_ONE), {16'h0, c});
		frame_in.crc_bad <= k[3];
		frame_in.is_pause <= k[2];
		frame_in.ingress_over <= k[1];
		sniff_mode <= k[0];
		frame_in.frame_len <= len;
		frame_in.length_type <= lt;
		send(e);
	endtask : fc

	task automatic wrap_up;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	always @(negedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0)
			chk({pslverr, prdata}, rq.pop_front());
		if (verdict.valid === 1'b1)
			chk({27'h0, verdict[5:0]}, {27'h0, vq.pop_front()});
	end

	initial begin
		#250000;
		miscompares++;
		wrap_up();
	end

	initial begin
		frame_in = '0;
		frame_in.length_type = 16'h0800;
		frame_in.payload_len = 11'd99;
		frame_in.frame_len = 11'd100;
		sniff_mode = 1'b0;
		port_link = 2'b00;
		seed = 32'h0D5A;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		wr(ABK, {26'h0, BANK_SWITCH});
		rd(ad(IDX_IDENT), {17'h0, FAM, CHP, REV, 1'b0});
		rd(ad(IDX_CTRL_ONE), {17'h0, 16'h3410});
		chk({27'h0, ctrl}, {27'h0, 6'b011100});
		send({3'b000, RSN_STOPPED});
		wr(ad(IDX_IDENT), 32'h0000FFFF);
		rd(ad(IDX_IDENT), {17'h0, FAM, CHP, REV, 1'b1});
		$display("ident and reset test done");
		for (int i = 0; i < 3; i++) begin
			seed = lfsr(seed);
			wr(ad(IDX_CTRL_ONE), {16'h0, seed[15:0]});
			rd(ad(IDX_CTRL_ONE), {17'h0, seed[15:0]});
			chk({27'h0, ctrl}, {27'h0, 1'b1, seed[13], seed[12], seed[10:8]});
		end
		$display("control word test done");
		for (int i = 0; i < 2; i++) begin
			b = i ? BANK_RSV_HI : BANK_RSV_LO;
			wr(ABK, {26'h0, b});
			rd(ad(IDX_IDENT), {1'b1, 32'h0});
			rd(ABK, {27'h0, b});
		end
		$display("reserved bank test done");
		wr(ABK, {26'h0, BANK_MCAST});
		rd(ad(IDX_MCAST_3), 33'h0);
		frame_in.dest_addr <= 48'h01005E0000FB;
		send({3'b000, RSN_MCAST});
		for (int i = 0; i < 8; i += 2)
			wr(ad(4'(i)), 32'h0000FFFF);
		send({3'b100, RSN_NONE});
		rd(ad(IDX_MCAST_3), {17'h0, 16'hFFFF});
		for (int i = 0; i < 8; i += 2)
			wr(ad(4'(i)), 32'h0);
		// only the selected bit passes; every other bit of its word does not
		b = hsh(48'h01005E0000FB);
		msk = 16'h0001 << b[3:0];
		for (int i = 0; i < 2; i++) begin
			wr(ad({1'b0, b[5:4], 1'b0}), {16'h0, i ? ~msk : msk});
			send(i ? {3'b000, RSN_MCAST} : {3'b100, RSN_NONE});
		end
		wr(ad({1'b0, b[5:4], 1'b0}), 32'h0);
		for (int m = 1; m < 3; m++) begin
			wr(ad(IDX_RX_CTRL), 32'(m));
			send({3'b100, RSN_NONE});
		end
		wr(ad(IDX_RX_CTRL), 32'h0);
		send({3'b000, RSN_MCAST});
		frame_in.dest_addr <= '0;
		$display("multicast test done");
		wr(ABK, {26'h0, BANK_SWITCH});
		fc(16'hB410, 4'b1000, 11'd100, 16'h0800, {3'b000, RSN_BAD});
		fc(16'h3410, 4'b1001, 11'd100, 16'h0800, {3'b000, RSN_BAD});
		fc(16'hB410, 4'b1001, 11'd100, 16'h0800, {3'b100, RSN_NONE});
		fc(16'h3C10, 4'b0000, 11'd100, 16'd100, {3'b000, RSN_LENGTH});
		fc(16'h3C10, 4'b0000, 11'd100, 16'd99, {3'b100, RSN_NONE});
		fc(16'h3400, 4'b0000, 11'd2001, 16'h0800, {3'b000, RSN_SIZE});
		fc(16'h3400, 4'b0000, 11'd2000, 16'h0800, {3'b100, RSN_NONE});
		fc(16'h3410, 4'b0100, 11'd100, 16'h0800, {3'b001, RSN_PAUSE});
		fc(16'h3418, 4'b0100, 11'd100, 16'h0800, {3'b101, RSN_NONE});
		fc(16'h2418, 4'b0100, 11'd100, 16'h0800, {3'b100, RSN_NONE});
		fc(16'h3410, 4'b0010, 11'd100, 16'h0800, {3'b000, RSN_INGRESS});
		fc(16'h3430, 4'b0010, 11'd100, 16'h0800, {3'b110, RSN_NONE});
		fc(16'h1430, 4'b0010, 11'd100, 16'h0800, {3'b100, RSN_NONE});
		frame_in.ingress_over <= 1'b0;
		$display("frame filter test done");
		for (int k = 0; k < 2; k++) begin
			// aging off clears the timer, so no normal tick lands near the link loss
			wr(ad(IDX_CTRL_ONE), 32'h3010);
			wr(ad(IDX_CTRL_ONE), k ? 32'h3411 : 32'h3410);
			port_link <= 2'b11;
			repeat (8) @(posedge clk);
			port_link <= k ? 2'b01 : 2'b10;
			n = 0;
			while (age_flush !== 1'b1 && n < 10) begin
				@(posedge clk);
				n++;
			end
			chk({32'h0, age_flush}, 33'h1);
		end
		n = 0;
		while (age_tick !== 1'b1 && n < 30) begin
			@(posedge clk);
			n++;
		end
		chk({32'h0, age_tick}, 33'h1);
		@(posedge clk);
		n = 0;
		while (age_tick !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk({32'h0, n > 30}, 33'h1);
		wr(ad(IDX_CTRL_ONE), 32'h3010);
		repeat (2) @(posedge clk);
		n = 0;
		repeat (250) begin
			@(posedge clk);
			if (age_tick === 1'b1)
				n++;
		end
		chk(33'(n), 33'h0);
		$display("aging test done");
		repeat (4) @(posedge clk);
		wrap_up();
	end
endmodule : switch_global_config_regs_test
